/* File: logic/word_store_defines.svh */
`ifndef WORD_STORE_DEFINES_SVH
`define WORD_STORE_DEFINES_SVH
`define WS_OFS_LONG_W 16
`define WS_OFS_SHORT_W 9
`define WS_ALIGN_MASK 2'h3
`define WS_BYTE_MAX 2'h3
`endif

/* File: logic/word_store_pkg.sv */
`default_nettype none
package word_store_pkg;
  // ****************
  // store kinds
  // ****************
  typedef enum logic [2:0] {
    store_word_aligned = 3'h0,
    store_fp_word = 3'h1,
    store_coproc_two_word = 3'h2,
    store_word_user_space = 3'h3,
    store_word_left_part = 3'h4,
    store_word_left_user_space = 3'h5
  } store_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_XLATE = 2'h1,
    ST_MEM = 2'h2
  } store_state_e;
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_ADDR = 3'h1,
    EXC_RESV = 3'h2,
    EXC_COP_UNUSABLE = 3'h3,
    EXC_XLATE = 3'h4
  } store_exc_e;
endpackage
`default_nettype wire

/* File: logic/word_store_unit.sv */
`include "word_store_defines.svh"
`default_nettype none
module word_store_unit
  import word_store_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // instruction request
  input wire logic req_valid_i,
  input wire store_op_e req_op_i,
  input wire logic [31:0] base_value_i,
  input wire logic [15:0] offset_i,
  input wire logic [31:0] gpr_data_i,
  input wire logic [63:0] float_register_i,
  input wire logic [31:0] cop2_data_i,
  output logic req_ready_o,
  // mode and configuration
  input wire logic kernel_mode_i,
  input wire logic fpu_usable_i,
  input wire logic fpu_present_i,
  input wire logic cop2_usable_i,
  input wire logic cop2_present_i,
  input wire logic enhanced_va_present_bit_i,
  input wire logic segment_mode_ok_i,
  input wire logic cpu_big_endian_flag_i,
  input wire logic reverse_endian_flag_i,
  input wire logic memory_big_endian_flag_i,
  // translation
  output logic xlate_req_o,
  output logic [ADDR_W-1:0] xlate_vaddr_o,
  output logic xlate_user_map_o,
  input wire logic xlate_done_i,
  input wire logic xlate_fault_i,
  input wire logic [ADDR_W-1:0] xlate_paddr_i,
  input wire logic [2:0] xlate_cca_i,
  // memory store
  output logic mem_valid_o,
  output logic [2:0] mem_cca_o,
  output logic [1:0] mem_size_o,
  output logic [31:0] mem_data_o,
  output logic [ADDR_W-1:0] mem_paddr_o,
  output logic [ADDR_W-1:0] mem_vaddr_o,
  input wire logic mem_ready_i,
  // completion
  output logic done_o,
  output store_exc_e exc_o
);

  // ****************
  // state
  // ****************
  typedef struct packed {
    store_state_e st;
    logic ready;
    logic xreq;
    logic [ADDR_W-1:0] vaddr;
    logic umap;
    logic left;
    logic [31:0] data;
    logic mvalid;
    logic [2:0] cca;
    logic [1:0] size;
    logic [31:0] mdata;
    logic [ADDR_W-1:0] paddr;
    logic done;
    store_exc_e exc;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic user_op;
  logic [ADDR_W-1:0] ea;
  logic [1:0] byte_idx;
  logic [1:0] plow;

  always_comb begin
    user_op = (req_op_i == store_word_user_space) || (req_op_i == store_word_left_user_space);
    // short offset keeps only the low nine bits of the field
    if (user_op) begin
      ea = base_value_i + {{(ADDR_W - `WS_OFS_SHORT_W){offset_i[`WS_OFS_SHORT_W-1]}},
                           offset_i[`WS_OFS_SHORT_W-1:0]};
    end else begin
      ea = base_value_i + {{(ADDR_W - `WS_OFS_LONG_W){offset_i[15]}}, offset_i};
    end
    byte_idx = s_q.vaddr[1:0] ^ {2{cpu_big_endian_flag_i}};
    plow = xlate_paddr_i[1:0] ^ {2{reverse_endian_flag_i}};
    if (!memory_big_endian_flag_i) begin
      plow = 2'h0;
    end
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (req_valid_i) begin
          s_d.ready = 1'b0;
          s_d.vaddr = ea;
          s_d.umap = user_op;
          s_d.left = (req_op_i == store_word_left_part) ||
                     (req_op_i == store_word_left_user_space);
          s_d.exc = EXC_NONE;
          unique case (req_op_i)
            store_fp_word: s_d.data = float_register_i[31:0];
            store_coproc_two_word: s_d.data = cop2_data_i;
            default: s_d.data = gpr_data_i;
          endcase
          // priority: missing instruction, unusable unit, refused segment, then alignment
          if (user_op && (!enhanced_va_present_bit_i || !kernel_mode_i)) begin
            s_d.exc = EXC_RESV;
          end else if (req_op_i == store_fp_word && !fpu_present_i) begin
            s_d.exc = EXC_RESV;
          end else if (req_op_i == store_coproc_two_word && !cop2_present_i) begin
            s_d.exc = EXC_RESV;
          end else if (req_op_i == store_fp_word && !fpu_usable_i) begin
            s_d.exc = EXC_COP_UNUSABLE;
          end else if (req_op_i == store_coproc_two_word && !cop2_usable_i) begin
            s_d.exc = EXC_COP_UNUSABLE;
          end else if (user_op && !segment_mode_ok_i) begin
            s_d.exc = EXC_ADDR;
          end else if (!s_d.left && (ea[1:0] & `WS_ALIGN_MASK) != 2'h0) begin
            s_d.exc = EXC_ADDR;
          end
          if (s_d.exc != EXC_NONE) begin
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
          end else begin
            s_d.xreq = 1'b1;
            s_d.st = ST_XLATE;
          end
        end
      end
      ST_XLATE: begin
        if (xlate_done_i) begin
          s_d.xreq = 1'b0;
          if (xlate_fault_i) begin
            s_d.exc = EXC_XLATE;
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = ST_IDLE;
          end else begin
            s_d.mvalid = 1'b1;
            s_d.cca = xlate_cca_i;
            if (s_q.left) begin
              s_d.paddr = {xlate_paddr_i[ADDR_W-1:2], plow};
              s_d.size = byte_idx;
              s_d.mdata = s_q.data >> (8 * (`WS_BYTE_MAX - byte_idx));
            end else begin
              s_d.paddr = xlate_paddr_i;
              s_d.size = `WS_BYTE_MAX;
              s_d.mdata = s_q.data;
            end
            s_d.st = ST_MEM;
          end
        end
      end
      ST_MEM: begin
        if (mem_ready_i) begin
          s_d.mvalid = 1'b0;
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{st: ST_IDLE, ready: 1'b1, exc: EXC_NONE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready_o = s_q.ready;
  assign xlate_req_o = s_q.xreq;
  assign xlate_vaddr_o = s_q.vaddr;
  assign xlate_user_map_o = s_q.umap;
  assign mem_valid_o = s_q.mvalid;
  assign mem_cca_o = s_q.cca;
  assign mem_size_o = s_q.size;
  assign mem_data_o = s_q.mdata;
  assign mem_paddr_o = s_q.paddr;
  assign mem_vaddr_o = s_q.vaddr;
  assign done_o = s_q.done;
  assign exc_o = s_q.exc;

  // ****************
  // checks
  // ****************
  AST_MISALIGN_NO_XLATE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_aligned && ea[1:0] != 2'h0
    |=> !xlate_req_o && done_o && exc_o == EXC_ADDR)
    else $error("misaligned store reached translation");
  AST_MISALIGN_NO_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o && exc_o == EXC_ADDR |-> !mem_valid_o)
    else $error("write issued after address error");
  AST_FP_ALIGN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_fp_word && fpu_present_i &&
    fpu_usable_i && ea[1:0] != 2'h0 |=> exc_o == EXC_ADDR)
    else $error("float store misalignment not caught");
  AST_LEFT_NO_ALIGN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_left_part |=> xlate_req_o)
    else $error("left store refused");
  AST_USER_NEEDS_EVA: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_user_space &&
    !enhanced_va_present_bit_i |=> exc_o == EXC_RESV && !xlate_req_o)
    else $error("user store ran without enhanced addressing");
  AST_USER_MAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_user_space |=> xlate_user_map_o)
    else $error("user store not using user mapping");
  AST_CCA_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_XLATE && xlate_done_i && !xlate_fault_i |=> mem_valid_o &&
    mem_cca_o == $past(xlate_cca_i))
    else $error("attribute not forwarded");
  AST_LEFT_DATA: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mem_valid_o && s_q.left |-> mem_data_o == (s_q.data >> (8 * (2'h3 - mem_size_o))))
    else $error("left store data wrong");
  AST_WORD_SIZE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mem_valid_o && !s_q.left |-> mem_size_o == 2'h3 && mem_data_o == s_q.data)
    else $error("word store size wrong");
  AST_MEMLE_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_XLATE && xlate_done_i && !xlate_fault_i && s_q.left &&
    !memory_big_endian_flag_i |=> mem_paddr_o[1:0] == 2'h0)
    else $error("low address bits not cleared");
  AST_WORD_EXC_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_aligned |=>
    exc_o == EXC_NONE || exc_o == EXC_ADDR)
    else $error("word store raised a foreign fault");
  AST_FP_UNUSABLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_fp_word && fpu_present_i &&
    !fpu_usable_i |=> done_o && exc_o == EXC_COP_UNUSABLE && !xlate_req_o)
    else $error("float store ran with unit unusable");
  AST_FP_ABSENT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_fp_word && !fpu_present_i
    |=> done_o && exc_o == EXC_RESV && !xlate_req_o)
    else $error("float store ran with unit absent");
  AST_COP2_ALIGN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_coproc_two_word &&
    cop2_present_i && cop2_usable_i && ea[1:0] != 2'h0 |=> done_o && exc_o == EXC_ADDR)
    else $error("coprocessor store misalignment not caught");
  AST_USER_KERNEL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && user_op && enhanced_va_present_bit_i &&
    !kernel_mode_i |=> done_o && exc_o == EXC_RESV && !xlate_req_o)
    else $error("user-space store ran outside kernel mode");
  AST_USER_SEGMENT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && user_op && enhanced_va_present_bit_i &&
    kernel_mode_i && !segment_mode_ok_i |=> done_o && exc_o == EXC_ADDR && !xlate_req_o)
    else $error("user-space store reached a refused segment");
  AST_LEFT_USER_EVA: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_left_user_space &&
    !enhanced_va_present_bit_i |=> done_o && exc_o == EXC_RESV && !xlate_req_o)
    else $error("user-space left store ran without enhanced addressing");
  AST_LEFT_USER_MAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_IDLE && req_valid_i && req_op_i == store_word_left_user_space &&
    enhanced_va_present_bit_i && kernel_mode_i && segment_mode_ok_i |=>
    xlate_req_o && xlate_user_map_o)
    else $error("user-space left store not using user mapping");
  AST_XLATE_FAULT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_XLATE && xlate_done_i && xlate_fault_i |=>
    done_o && exc_o == EXC_XLATE && !mem_valid_o)
    else $error("translation fault not reported");
  AST_LEFT_SIZE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_XLATE && xlate_done_i && !xlate_fault_i && s_q.left |=>
    mem_size_o == (mem_vaddr_o[1:0] ^ {2{$past(cpu_big_endian_flag_i)}}))
    else $error("left store byte count wrong");
  AST_WORD_PADDR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st == ST_XLATE && xlate_done_i && !xlate_fault_i && !s_q.left |=>
    mem_paddr_o == $past(xlate_paddr_i))
    else $error("word store address not forwarded");
  AST_MEM_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_data_o) &&
    $stable(mem_paddr_o) && $stable(mem_size_o))
    else $error("memory request changed while waiting");
  AST_XREQ_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    xlate_req_o && !xlate_done_i |=> xlate_req_o && $stable(xlate_vaddr_o))
    else $error("translation request dropped early");
  AST_BUSY_REFUSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_q.st != ST_IDLE |-> !req_ready_o)
    else $error("ready shown while busy");
  COV_USER_STORE: cover property (@(posedge clk_i) xlate_req_o && xlate_user_map_o);
  COV_WORD: cover property (@(posedge clk_i) mem_valid_o && mem_ready_i && !s_q.left);
  COV_LEFT: cover property (@(posedge clk_i) mem_valid_o && mem_ready_i && s_q.left);
  COV_ADDR_ERR: cover property (@(posedge clk_i) done_o && exc_o == EXC_ADDR);
  COV_XLATE_ERR: cover property (@(posedge clk_i) done_o && exc_o == EXC_XLATE);

endmodule
`default_nettype wire

/* File: verif/xlate_mem_model.sv */
`default_nettype none
module xlate_mem_model #(
  parameter logic [2:0] CCA_VAL = 3'h5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // bench controls
  input wire logic slow_i,
  input wire logic fault_i,
  // translation
  input wire logic xlate_req_i,
  input wire logic [31:0] xlate_vaddr_i,
  output logic xlate_done_o,
  output logic xlate_fault_o,
  output logic [31:0] xlate_paddr_o,
  output logic [2:0] xlate_cca_o,
  // memory store
  input wire logic mem_valid_i,
  output logic mem_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 2'h0;
      xlate_done_o <= 1'b0;
      mem_ready_o <= 1'b0;
      xlate_fault_o <= 1'b0;
      xlate_paddr_o <= 32'h0;
      xlate_cca_o <= 3'h0;
    end else begin
      xlate_done_o <= 1'b0;
      mem_ready_o <= 1'b0;
      // answer lines only mean something with done, so keep them moving
      xlate_fault_o <= ~xlate_fault_o;
      xlate_paddr_o <= ~xlate_paddr_o;
      xlate_cca_o <= ~xlate_cca_o;
      if ((xlate_req_i && !xlate_done_o) || (mem_valid_i && !mem_ready_o)) begin
        cnt_q <= cnt_q + 2'h1;
        if (!slow_i || cnt_q == 2'h3) begin
          cnt_q <= 2'h0;
          if (xlate_req_i) begin
            xlate_done_o <= 1'b1;
            xlate_fault_o <= fault_i;
            // flip a high bit only: low bits stay visible for the byte checks
            xlate_paddr_o <= xlate_vaddr_i ^ 32'h0100_0000;
            xlate_cca_o <= CCA_VAL;
          end else begin
            mem_ready_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/word_store_unit_tb.sv */
`default_nettype none
module word_store_unit_tb
  import word_store_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0, be = 1'b0, rev = 1'b0, mbe = 1'b0;
  logic kern = 1'b1, fpu_u = 1'b1, fpu_p = 1'b1, cp_u = 1'b1, cp_p = 1'b1, eva = 1'b1;
  logic seg = 1'b1, slow = 1'b0, fault = 1'b0, req_ready_o, xlate_req_o, xlate_user_map_o;
  logic xlate_done_i, xlate_fault_i, mem_valid_o, mem_ready_i, done_o;
  store_op_e req_op_i = store_word_aligned;
  store_exc_e exc_o;
  logic [31:0] base_value_i = 32'h0, gpr = 32'hA1B2_C3D4, cp2 = 32'h5566_7788;
  logic [63:0] float_register = 64'hDEAD_BEEF_1234_5678;
  logic [15:0] offset_i = 16'h0;
  logic [31:0] xlate_vaddr_o, xlate_paddr_i, mem_data_o, mem_paddr_o, mem_vaddr_o;
  logic [2:0] xlate_cca_i, mem_cca_o;
  logic [1:0] mem_size_o;
  int failures = 0, n_checks = 0;
  always #25 clk_i = ~clk_i;
  word_store_unit u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
    .req_op_i(req_op_i), .base_value_i(base_value_i), .offset_i(offset_i), .gpr_data_i(gpr),
    .float_register_i(float_register), .cop2_data_i(cp2), .req_ready_o(req_ready_o), .kernel_mode_i(kern),
    .fpu_usable_i(fpu_u), .fpu_present_i(fpu_p), .cop2_usable_i(cp_u), .cop2_present_i(cp_p),
    .enhanced_va_present_bit_i(eva), .segment_mode_ok_i(seg), .cpu_big_endian_flag_i(be),
    .reverse_endian_flag_i(rev), .memory_big_endian_flag_i(mbe), .xlate_req_o(xlate_req_o),
    .xlate_vaddr_o(xlate_vaddr_o), .xlate_user_map_o(xlate_user_map_o),
    .xlate_done_i(xlate_done_i), .xlate_fault_i(xlate_fault_i), .xlate_paddr_i(xlate_paddr_i),
    .xlate_cca_i(xlate_cca_i), .mem_valid_o(mem_valid_o), .mem_cca_o(mem_cca_o),
    .mem_size_o(mem_size_o), .mem_data_o(mem_data_o), .mem_paddr_o(mem_paddr_o),
    .mem_vaddr_o(mem_vaddr_o), .mem_ready_i(mem_ready_i), .done_o(done_o), .exc_o(exc_o));
  xlate_mem_model u_far (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow), .fault_i(fault),
    .xlate_req_i(xlate_req_o), .xlate_vaddr_i(xlate_vaddr_o), .xlate_done_o(xlate_done_i),
    .xlate_fault_o(xlate_fault_i), .xlate_paddr_o(xlate_paddr_i), .xlate_cca_o(xlate_cca_i),
    .mem_valid_i(mem_valid_o), .mem_ready_o(mem_ready_i));
  // ****************
  // checking
  // ****************
  task give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one store, entered and left at a falling edge
  task store(input store_op_e op, input logic [31:0] base, input logic [15:0] ofs,
             input store_exc_e ee);
    logic [31:0] va, ed;
    logic [1:0] idx, plo;
    logic user, left, seen;
    int k;
    user = op inside {store_word_user_space, store_word_left_user_space};
    left = op inside {store_word_left_part, store_word_left_user_space};
    va = base + (user ? {{23{ofs[8]}}, ofs[8:0]} : {{16{ofs[15]}}, ofs});
    idx = va[1:0] ^ {2{be}};
    ed = op == store_fp_word ? float_register[31:0] : op == store_coproc_two_word ? cp2 : gpr;
    ed = left ? gpr >> (8 * (3 - idx)) : ed;
    plo = !left ? va[1:0] : mbe ? va[1:0] ^ {2{rev}} : 2'h0;
    seen = 1'b0;
    req_valid_i = 1'b1;
    req_op_i = op;
    base_value_i = base;
    offset_i = ofs;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (k = 0; k < 40 && !done_o; k++) begin
      chk("busy", req_ready_o, 1'b0);
      if (xlate_req_o) begin
        chk("user_map", xlate_user_map_o, user);
      end
      if (mem_valid_o && !seen) begin
        seen = 1'b1;
        chk("cca", mem_cca_o, 3'h5);
        chk("size", mem_size_o, left ? idx : 2'h3);
        chk("data", mem_data_o, ed);
        chk("paddr", mem_paddr_o, {va[31:2] ^ 30'h0040_0000, plo});
        chk("vaddr", mem_vaddr_o, va);
      end
      @(negedge clk_i);
    end
    if (k == 40) begin
      failures++;
      give_verdict();
    end else begin
      chk("ready", req_ready_o, 1'b1);
      chk("exc", exc_o, ee);
      chk("mem_write", seen, ee == EXC_NONE);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    @(negedge clk_i);
    store(store_word_aligned, 32'h0000_1000, 16'hFFFC, EXC_NONE);
    store(store_word_aligned, 32'h0000_1000, 16'h0001, EXC_ADDR);
    store(store_fp_word, 32'h0000_2000, 16'h0008, EXC_NONE);
    store(store_fp_word, 32'h0000_2000, 16'h0002, EXC_ADDR);
    fpu_u = 1'b0;
    store(store_fp_word, 32'h0000_2000, 16'h0008, EXC_COP_UNUSABLE);
    fpu_p = 1'b0;
    store(store_fp_word, 32'h0000_2000, 16'h0008, EXC_RESV);
    fpu_u = 1'b1;
    fpu_p = 1'b1;
    store(store_coproc_two_word, 32'h0000_3000, 16'h0004, EXC_NONE);
    store(store_coproc_two_word, 32'h0000_3000, 16'h0003, EXC_ADDR);
    slow = 1'b1;
    store(store_word_user_space, 32'h0000_2001, 16'h01FF, EXC_NONE);
    store(store_word_user_space, 32'h0000_2000, 16'h0002, EXC_ADDR);
    kern = 1'b0;
    store(store_word_user_space, 32'h0000_2001, 16'h01FF, EXC_RESV);
    kern = 1'b1;
    eva = 1'b0;
    store(store_word_left_user_space, 32'h0000_2001, 16'h0000, EXC_RESV);
    eva = 1'b1;
    seg = 1'b0;
    store(store_word_user_space, 32'h0000_2001, 16'h01FF, EXC_ADDR);
    seg = 1'b1;
    slow = 1'b0;
    // every offset against both byte orders and memory modes
    for (int i = 0; i < 16; i++) begin
      be = i[0];
      mbe = i[3];
      rev = i[3] ^ i[0];
      store(store_word_left_part, 32'h0000_4000 | i[2:1], 16'h0000, EXC_NONE);
    end
    store(store_word_left_user_space, 32'h0000_5003, 16'h0100, EXC_NONE);
    fault = 1'b1;
    store(store_word_left_part, 32'h0000_4001, 16'h0000, EXC_XLATE);
    fault = 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
